// [bench/test_pattern_bist_control_tb_top.sv]
// Self-checking bench for the test pattern and self-test control block
`timescale 1ns/1ps
`include "tpb_map.svh"
module test_pattern_bist_control_tb_top;
  typedef struct {logic [15:0] wd; logic [15:0] rd; logic act; logic [1:0] sel;} tpb_row_t;
  logic        pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, nibble_valid, nibble_error, pattern_active, sequence_send;
  logic        continuous_pattern_tx, jabber_enable, core_reset, irq, e;
  logic [1:0]  pattern_choice;
  int          n_errors = 0, checks_done = 0, c0, c1;
  tpb_row_t    rows[5] = '{'{16'h0010, 16'h0010, 1'b1, 2'h0}, '{16'h0011, 16'h0011, 1'b1, 2'h1},
                           '{16'h0016, 16'h0016, 1'b1, 2'h2}, '{16'h0013, 16'h0013, 1'b1, 2'h3},
                           '{16'hffcb, 16'h0003, 1'b0, 2'h3}};
  // Clock at 20 MHz
  always #25 pclk = ~pclk;
  tpb_control #(.GAP_LONG(8), .GAP_SHORT(4), .SOFT_CYC(16)) dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nibble_valid(nibble_valid), .nibble_error(nibble_error), .pattern_active(pattern_active),
    .pattern_choice(pattern_choice), .sequence_send(sequence_send),
    .continuous_pattern_tx(continuous_pattern_tx), .jabber_enable(jabber_enable),
    .core_reset(core_reset), .irq(irq));
  tpb_line_model line (.pclk(pclk), .nibble_valid(nibble_valid), .nibble_error(nibble_error));
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // One APB transfer; request held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++t < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("wrong value t=%0t bus timeout", $time);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Cycles between two sequence starts
  task meas(output int c);
    int t;
    t = 0;
    c = 0;
    do @(posedge pclk); while (sequence_send !== 1'b1 && ++t < 1000);
    do begin @(posedge pclk); c++; end while (sequence_send !== 1'b1 && c < 1000);
  endtask : meas
  task end_sim;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // Watchdog well past the expected run length
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    $display("wrong value t=%0t timeout", $time);
    end_sim();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(jabber_enable), 32'h1, "jabber rst"); // jabber on at reset
    apb(0, `TPB_ADDR_DRV_TEST, 0); chk(q, 32'h0, "drv rst"); // pattern off at reset
    apb(0, `TPB_OFF_TENBASE, 0); chk(q, 32'h4, "tenbase rst");
    $display("reset test done");
    foreach (rows[i]) begin
      apb(1, `TPB_ADDR_DRV_TEST, 32'(rows[i].wd));
      apb(0, `TPB_ADDR_DRV_TEST, 0); chk(q, 32'(rows[i].rd), "row readback"); // select readback
      chk(32'(pattern_active), 32'(rows[i].act), "active"); // enable bit
      if (rows[i].act) chk(32'(pattern_choice), 32'(rows[i].sel), "choice"); // pattern select
    end
    $display("table test done");
    apb(1, `TPB_ADDR_DRV_TEST, 32'h10); meas(c0); meas(c0);
    apb(1, `TPB_ADDR_DRV_TEST, 32'h14); meas(c1); meas(c1);
    chk(32'(c1 - c0), 32'd4, "gap"); // long minus short gap
    $display("gap test done");
    apb(1, `TPB_OFF_TENBASE, 32'h5); // jabber off before continuous mode
    // Registered outputs follow a write one edge later; look once settled
    @(negedge pclk);
    chk(32'(jabber_enable), 32'h0, "jabber off"); // jabber disabled
    apb(1, `TPB_ADDR_DRV_TEST, 32'h20); apb(1, `TPB_OFF_MAIN_CTRL, 32'h0);
    chk(32'(continuous_pattern_tx), 32'h0, "cont no run"); // needs run bit
    apb(1, `TPB_OFF_MAIN_CTRL, 32'h1);
    @(negedge pclk);
    chk(32'(continuous_pattern_tx), 32'h1, "cont run"); // continuous on
    $display("continuous test done");
    line.send(10); apb(0, `TPB_ADDR_DRV_TEST, 0);
    chk(32'(q[15:8]), 32'd10, "tally"); // errored nibbles counted
    // Frozen clock enable: errored nibbles must leave the tally alone
    clk_en <= 1'b0;
    line.send(5);
    clk_en <= 1'b1;
    apb(0, `TPB_ADDR_DRV_TEST, 0); chk(32'(q[15:8]), 32'd10, "tally frozen"); // no count while frozen
    line.send(300); apb(0, `TPB_ADDR_DRV_TEST, 0);
    chk(32'(q[15:8]), 32'd255, "tally sat"); // holds at 255
    chk(32'(irq), 32'h0, "irq masked");
    apb(1, `TPB_OFF_IRQ_MASK, 32'h1); @(posedge pclk); chk(32'(irq), 32'h1, "irq up");
    apb(1, `TPB_OFF_IRQ_STATUS, 32'h1); @(posedge pclk); chk(32'(irq), 32'h0, "irq clr");
    apb(1, `TPB_OFF_MAIN_CTRL, 32'h0); apb(1, `TPB_OFF_MAIN_CTRL, 32'h1);
    apb(0, `TPB_ADDR_DRV_TEST, 0); chk(32'(q[15:8]), 32'd0, "tally restart"); // cleared on restart
    $display("tally test done");
    apb(1, `TPB_OFF_PHY_EXTRA, 32'h200); chk(32'(core_reset), 32'h1, "soft rst"); // core reset
    apb(0, `TPB_OFF_PHY_EXTRA, 0); chk(q, 32'h200, "soft busy"); // reads one while busy
    repeat (20) @(posedge pclk);
    apb(0, `TPB_OFF_PHY_EXTRA, 0); chk(q, 32'h0, "soft clr"); // self-clearing
    apb(0, `TPB_ADDR_DRV_TEST, 0); chk(32'(q[7:0]), 32'h20, "cfg kept"); // registers kept
    apb(0, `TPB_OFF_IRQ_STATUS, 0); chk(32'(q[1]), 32'h1, "soft done");
    apb(1, `TPB_OFF_PHY_EXTRA, 32'hfdff); apb(0, `TPB_OFF_PHY_EXTRA, 0);
    chk(q, 32'h0, "unused bits"); // read as zero
    apb(0, 12'h0fc, 0); chk(32'(e), 32'h1, "unmapped err"); chk(q, 32'h0, "unmapped rd");
    $display("soft reset test done");
    // Mid-run reset returns registers and outputs to reset state
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(jabber_enable), 32'h1, "jabber rerst"); // jabber back on
    apb(0, `TPB_ADDR_DRV_TEST, 0); chk(q, 32'h0, "drv rerst"); // pattern off again
    apb(0, `TPB_OFF_TENBASE, 0); chk(q, 32'h4, "tenbase rerst"); // disable bit cleared
    $display("mid-run reset test done");
    end_sim();
  end
endmodule : test_pattern_bist_control_tb_top

// [bench/tpb_line_model.sv]
// Line-side test equipment model that feeds received nibble flags
`timescale 1ns/1ps
module tpb_line_model (
  input  wire logic pclk,
  output logic      nibble_valid,
  output logic      nibble_error
);
  int   left = 0;
  logic v    = 1'b0;
  logic e    = 1'b0;
  assign nibble_valid = v;
  assign nibble_error = e;
  // Alternate good and errored nibbles; idle error flag toggles so a stale level never counts
  always @(posedge pclk) begin
    if (left > 0) begin
      v <= 1'b1;
      e <= left[0];
      left <= left - 1;
    end else begin
      v <= 1'b0;
      e <= ~e;
    end
  end
  // Send n errored nibbles, then let the synchroniser settle
  task send(input int n);
    @(posedge pclk);
    left <= 2 * n;
    repeat (2 * n + 8) @(posedge pclk);
  endtask : send
endmodule : tpb_line_model

// [hw/tpb_control.sv]
// APB register block and sequencer for driver test patterns and packet self-test
// Overview of operation
// [R1] Count errored received nibbles during self-test; show count in bits 15:8.
// [R2] Clear the errored-nibble count whenever self-test starts again.
// [R3] Count saturates at its maximum and never wraps.
// [R4] Bit 5 set: send pseudo-random self-test data with no inter-packet gap.
// [R5] Continuous transmission acts only while main-control self-test run bit is set.
// [R6] Software sets jabber-disable before continuous 10 Mb self-test transmission.
// [R7] Bit 4 enables 10 Mb test pattern generation; resets to zero.
// [R8] Bit 2 picks the gap between sequences: one gives 15 us, zero 10 us.
// [R9] Bits 1:0 pick pattern: variant A, variant B, link pulses, constant ones.
// [R10] Writing one to bit 9 resets core logic but not registers; self-clears.
// [R11] Unused bits of the extra control register ignore writes, read zero.
// [R12] Jabber-disable bit one turns jabber protection off; zero keeps it on.
// [R13] The errored-nibble count holds at 255.
`timescale 1ns/1ps
`include "tpb_map.svh"
module tpb_control
  import tpb_pkg::*;
#(
  parameter int GAP_LONG  = `TPB_GAP_LONG_CYC,
  parameter int GAP_SHORT = `TPB_GAP_SHORT_CYC,
  parameter int SOFT_CYC  = `TPB_SOFT_RST_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        nibble_valid,
  input  wire logic        nibble_error,
  output logic             pattern_active,
  output logic [1:0]       pattern_choice,
  output logic             sequence_send,
  output logic             continuous_pattern_tx,
  output logic             jabber_enable,
  output logic             core_reset,
  output logic             irq
);
  typedef struct packed {
    logic [15:0]    drv_test;
    logic [15:0]    tenbase;
    logic [15:0]    main_ctrl;
    logic [7:0]     tally;
    logic [1:0]     irq_status;
    logic [1:0]     irq_mask;
    logic [4:0]     soft_cnt;
    logic           soft_busy;
    logic [1:0]     err_sync;
    logic [1:0]     val_sync;
    tpb_seq_state_t seq;
    logic           gap_start;
    logic [31:0]    rdata;
    logic           ready;
    logic           slverr;
    logic           pat_on;
    logic [1:0]     pat_sel;
    logic           send;
    logic           cont_tx;
    logic           jab_en;
    logic           core_rst;
    logic           irq;
  } tpb_state_t;

  tpb_state_t state_reg;
  tpb_state_t state_next;
  logic       gap_done;

  // Decode a known register offset
  function automatic logic addr_known(input logic [11:0] a);
    return a == `TPB_ADDR_DRV_TEST || a == `TPB_OFF_PHY_EXTRA || a == `TPB_OFF_TENBASE ||
           a == `TPB_OFF_MAIN_CTRL || a == `TPB_OFF_IRQ_STATUS || a == `TPB_OFF_IRQ_MASK;
  endfunction : addr_known

  tpb_gap_timer #(
    .GAP_LONG  (GAP_LONG),
    .GAP_SHORT (GAP_SHORT)
  ) u_gap (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .start    (state_reg.gap_start),
    .long_gap (state_reg.drv_test[`TPB_BIT_GAP_SEL]),
    .done     (gap_done)
  );

  // Next state: bus slave, tally, sequencer, soft reset, interrupts
  always_comb begin
    logic        wr;
    logic        rd;
    logic        run;
    logic        restart;
    logic        err_ev;
    logic        sat_ev;
    logic        soft_done;
    logic [15:0] wv;
    wr        = 1'b0;
    rd        = 1'b0;
    run       = 1'b0;
    restart   = 1'b0;
    err_ev    = 1'b0;
    sat_ev    = 1'b0;
    soft_done = 1'b0;
    wv        = pwdata[15:0];
    state_next           = state_reg;
    state_next.ready     = 1'b0;
    state_next.slverr    = 1'b0;
    state_next.gap_start = 1'b0;
    // Pin inputs pass two flops; only the second stage is read
    state_next.err_sync  = {state_reg.err_sync[0], nibble_error};
    state_next.val_sync  = {state_reg.val_sync[0], nibble_valid};
    // One wait state: answer in the second cycle of the access phase
    if (psel && penable && !state_reg.ready) begin
      state_next.ready  = 1'b1;
      state_next.slverr = !addr_known(paddr);
      wr = pwrite && addr_known(paddr);
      rd = !pwrite;
    end
    run = state_reg.main_ctrl[`TPB_BIT_BIST_RUN];
    if (wr) begin
      case (paddr)
        `TPB_ADDR_DRV_TEST: state_next.drv_test = (state_reg.drv_test & ~`TPB_DRV_TEST_WMASK) |
                                                  (wv & `TPB_DRV_TEST_WMASK);
        `TPB_OFF_TENBASE:   state_next.tenbase = wv & `TPB_TENBASE_WMASK;
        `TPB_OFF_MAIN_CTRL: begin
          state_next.main_ctrl = wv;
          restart = wv[`TPB_BIT_BIST_RUN] && !run;
        end
        // [R10] Soft reset start
        `TPB_OFF_PHY_EXTRA: if (wv[`TPB_BIT_SOFT_RESET] && !state_reg.soft_busy) begin
          state_next.soft_busy = 1'b1;
          state_next.soft_cnt  = 5'(SOFT_CYC - 1);
        end
        `TPB_OFF_IRQ_MASK:  state_next.irq_mask = wv[1:0];
        default: ;
      endcase
    end
    // [R10] Self-clearing core reset
    if (state_reg.soft_busy) begin
      if (state_reg.soft_cnt == 5'h00) begin
        state_next.soft_busy = 1'b0;
        soft_done = 1'b1;
      end else begin
        state_next.soft_cnt = state_reg.soft_cnt - 5'h01;
      end
    end
    // [R1] Count errored nibbles while self-test runs
    err_ev = run && state_reg.err_sync[1] && state_reg.val_sync[1] && !state_reg.soft_busy;
    // [R2] Restart clears the tally
    if (restart) begin
      state_next.tally = 8'h00;
    // [R3] Saturating count
    end else if (err_ev && state_reg.tally != `TPB_TALLY_MAX) begin
      state_next.tally = state_reg.tally + 8'h01;
      // [R13] Reaching 255 raises the saturation event
      sat_ev = (state_reg.tally == 8'hfe);
    end
    // Sequencer; idle while core is in soft reset
    state_next.pat_on  = state_reg.drv_test[`TPB_BIT_PATT_ON] && !state_reg.soft_busy;
    state_next.pat_sel = state_reg.drv_test[1:0];
    case (state_reg.seq)
      TPB_SEQ_IDLE: begin
        // [R7] Pattern generation only when enabled
        if (state_next.pat_on) begin
          state_next.seq  = TPB_SEQ_SEND;
          state_next.send = 1'b1;
        end
      end
      TPB_SEQ_SEND: begin
        state_next.send = 1'b0;
        // [R9] Constant ones streams without gaps
        if (!state_next.pat_on) begin
          state_next.seq = TPB_SEQ_IDLE;
        end else if (state_reg.pat_sel != TPB_PAT_ONES) begin
          // [R8] Gap length from the gap select bit
          state_next.seq       = TPB_SEQ_GAP;
          state_next.gap_start = 1'b1;
        end else begin
          state_next.send = 1'b1;
        end
      end
      TPB_SEQ_GAP: begin
        if (!state_next.pat_on) begin
          state_next.seq = TPB_SEQ_IDLE;
        end else if (gap_done) begin
          state_next.seq  = TPB_SEQ_SEND;
          state_next.send = 1'b1;
        end
      end
      default: state_next.seq = TPB_SEQ_IDLE;
    endcase
    // [R4] [R5] Continuous mode needs the main run bit; [R6] is software's duty
    state_next.cont_tx  = state_reg.drv_test[`TPB_BIT_CONT_TX] && run && !state_reg.soft_busy;
    // [R12] Jabber protection off only when disable bit is one
    state_next.jab_en   = !state_reg.tenbase[`TPB_BIT_JABBER_DIS];
    state_next.core_rst = state_next.soft_busy;
    // Interrupts: set wins over write-one-to-clear
    if (wr && paddr == `TPB_OFF_IRQ_STATUS) begin
      state_next.irq_status = state_reg.irq_status & ~wv[1:0];
    end
    if (sat_ev) state_next.irq_status[`TPB_IRQ_SATURATED] = 1'b1;
    if (soft_done) state_next.irq_status[`TPB_IRQ_SOFT_DONE] = 1'b1;
    state_next.irq = |(state_next.irq_status & state_next.irq_mask);
    // Read mux; [R11] extra control reads zero, soft reset reads back while busy
    if (rd) begin
      case (paddr)
        `TPB_ADDR_DRV_TEST:  state_next.rdata = {16'h0000, state_reg.tally, state_reg.drv_test[7:0]};
        `TPB_OFF_PHY_EXTRA:  state_next.rdata = {22'h0, state_reg.soft_busy, 9'h000};
        `TPB_OFF_TENBASE:    state_next.rdata = {16'h0000, state_reg.tenbase};
        `TPB_OFF_MAIN_CTRL:  state_next.rdata = {16'h0000, state_reg.main_ctrl};
        `TPB_OFF_IRQ_STATUS: state_next.rdata = {30'h0, state_reg.irq_status};
        `TPB_OFF_IRQ_MASK:   state_next.rdata = {30'h0, state_reg.irq_mask};
        default:             state_next.rdata = 32'h00000000;
      endcase
    end
  end

  // State register, frozen while clock enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg         <= '0;
      state_reg.tenbase <= `TPB_TENBASE_RESET;
      state_reg.seq     <= TPB_SEQ_IDLE;
      state_reg.jab_en  <= 1'b1;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign prdata                = state_reg.rdata;
  assign pready                = state_reg.ready;
  assign pslverr               = state_reg.slverr;
  assign pattern_active        = state_reg.pat_on;
  assign pattern_choice        = state_reg.pat_sel;
  assign sequence_send         = state_reg.send;
  assign continuous_pattern_tx = state_reg.cont_tx;
  assign jabber_enable         = state_reg.jab_en;
  assign core_reset            = state_reg.core_rst;
  assign irq                   = state_reg.irq;

  // Assertions
  // Restart write seen on the bus; the run bit alone cannot tell a restart
  logic restart_seen;
  assign restart_seen = psel && penable && pwrite && !state_reg.ready &&
                        paddr == `TPB_OFF_MAIN_CTRL &&
                        pwdata[`TPB_BIT_BIST_RUN] && !state_reg.main_ctrl[`TPB_BIT_BIST_RUN];

  // Restart write accepted on an enabled clock
  sequence s_restart;
    restart_seen && clk_en;
  endsequence

  // Tally parked at its top value, no restart pending
  sequence s_tally_parked;
    clk_en && state_reg.tally == `TPB_TALLY_MAX && !restart_seen;
  endsequence

  // Soft reset write accepted while the core runs normally
  sequence s_soft_write;
    psel && penable && pwrite && !state_reg.ready && clk_en &&
    paddr == `TPB_OFF_PHY_EXTRA && pwdata[`TPB_BIT_SOFT_RESET] && !core_reset;
  endsequence

  // Read answer from the extra control register
  sequence s_extra_read;
    pready && !pwrite && paddr == `TPB_OFF_PHY_EXTRA;
  endsequence

  // [R3] Tally never wraps
  a_tally_no_wrap: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    $past(state_reg.tally) == 8'hff && state_reg.tally != 8'hff |-> $past(restart_seen))
    else $error("tally wrapped");

  // [R13] Holds at top
  a_tally_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
    s_tally_parked |=> state_reg.tally == `TPB_TALLY_MAX)
    else $error("tally left its top value");

  // [R2] Restart clears tally
  a_tally_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    s_restart |=> state_reg.tally == 8'h00)
    else $error("tally not cleared on restart");

  // [R10] Soft reset starts
  a_soft_start: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    s_soft_write |=> core_reset)
    else $error("soft reset did not start");

  // [R10] Soft reset self-clears; bound covers the largest counter load
  a_soft_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    $rose(core_reset) |-> ##[1:40] !core_reset)
    else $error("soft reset stuck");

  // [R11] Unused bits zero
  a_extra_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
    s_extra_read |-> prdata[31:10] == 22'h0 && prdata[8:0] == 9'h000)
    else $error("unused control bits not zero");

  // [R7] Pattern off follows
  a_pattern_off: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    clk_en && !state_reg.drv_test[`TPB_BIT_PATT_ON] |=> !pattern_active)
    else $error("pattern active while disabled");

  // [R5] Continuous tx only with run bit
  a_cont_needs_run: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    continuous_pattern_tx |-> $past(state_reg.main_ctrl[`TPB_BIT_BIST_RUN]) || !clk_en)
    else $error("continuous tx without run");

  // [R12] Jabber follows disable bit
  a_jabber_follow: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
    clk_en |=> jabber_enable == !$past(state_reg.tenbase[`TPB_BIT_JABBER_DIS]))
    else $error("jabber enable mismatch");
endmodule : tpb_control

// [hw/tpb_gap_timer.sv]
// Inter-sequence gap timer: counts the programmed idle time
`timescale 1ns/1ps
`include "tpb_map.svh"
module tpb_gap_timer
  import tpb_pkg::*;
#(
  parameter int GAP_LONG  = `TPB_GAP_LONG_CYC,
  parameter int GAP_SHORT = `TPB_GAP_SHORT_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic start,
  input  wire logic long_gap,
  output logic      done
);
  typedef struct packed {
    logic [9:0] count;
    logic       busy;
    logic       done;
  } tpb_gap_state_t;

  tpb_gap_state_t state_reg;
  tpb_gap_state_t state_next;

  // Load on start, count down, pulse done on the last cycle
  always_comb begin
    state_next      = state_reg;
    state_next.done = 1'b0;
    if (start) begin
      state_next.busy  = 1'b1;
      state_next.count = long_gap ? 10'(GAP_LONG - 1) : 10'(GAP_SHORT - 1);
    end else if (state_reg.busy) begin
      if (state_reg.count == 10'h000) begin
        state_next.busy = 1'b0;
        state_next.done = 1'b1;
      end else begin
        state_next.count = state_reg.count - 10'h001;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign done = state_reg.done;
endmodule : tpb_gap_timer

// [hw/tpb_map.svh]
// Register offsets, field positions, reset values and timing counts for the test pattern block
`ifndef TPB_MAP_SVH
`define TPB_MAP_SVH
// Register indices; the byte address is four times the index
`define TPB_OFF_DRV_TEST     12'h01b
`define TPB_IDX_PHY_EXTRA    12'h01c
`define TPB_IDX_TENBASE      12'h01a
`define TPB_IDX_MAIN_CTRL    12'h019
`define TPB_OFF_PHY_EXTRA    (`TPB_IDX_PHY_EXTRA * 12'h004)
`define TPB_OFF_TENBASE      (`TPB_IDX_TENBASE * 12'h004)
`define TPB_OFF_MAIN_CTRL    (`TPB_IDX_MAIN_CTRL * 12'h004)
`define TPB_OFF_IRQ_STATUS   12'h100
`define TPB_OFF_IRQ_MASK     12'h104
`define TPB_ADDR_DRV_TEST    (`TPB_OFF_DRV_TEST * 12'h004)
`define TPB_BIT_CONT_TX      5
`define TPB_BIT_PATT_ON      4
`define TPB_BIT_GAP_SEL      2
`define TPB_BIT_SOFT_RESET   9
`define TPB_BIT_JABBER_DIS   0
`define TPB_BIT_BIST_RUN     0
`define TPB_DRV_TEST_WMASK   16'h0037
`define TPB_TENBASE_RESET    16'h0004
`define TPB_TENBASE_WMASK    16'h00ef
`define TPB_TALLY_MAX        8'hff
`define TPB_GAP_LONG_NS      15000
`define TPB_GAP_SHORT_NS     10000
`define TPB_CLK_NS           50
`define TPB_GAP_LONG_CYC     (`TPB_GAP_LONG_NS / `TPB_CLK_NS)
`define TPB_GAP_SHORT_CYC    (`TPB_GAP_SHORT_NS / `TPB_CLK_NS)
`define TPB_SOFT_RST_CYC     16
`define TPB_IRQ_SATURATED    0
`define TPB_IRQ_SOFT_DONE    1
`endif

// [hw/tpb_pkg.sv]
// Types shared by the test pattern and self-test control block
package tpb_pkg;
  typedef enum logic [1:0] {
    TPB_PAT_EOP_A = 2'h0,
    TPB_PAT_EOP_B = 2'h1,
    TPB_PAT_NLP   = 2'h2,
    TPB_PAT_ONES  = 2'h3
  } tpb_pattern_t;

  typedef enum logic [2:0] {
    TPB_SEQ_IDLE = 3'b001,
    TPB_SEQ_SEND = 3'b010,
    TPB_SEQ_GAP  = 3'b100
  } tpb_seq_state_t;
endpackage : tpb_pkg
